// >>> verif/qdsc_host.sv
// Serial host model driving the command link of the converter block
`timescale 1ns/1ps
`default_nettype none
module qdsc_host (
	input wire logic clk, // Bench clock
	input wire logic serial_out, // Data back from the block
	output logic sclk, // Serial clock
	output logic chip_select_n, // Select, low
	output logic serial_in // Data to the block
);
	// *****
	// Frame sender
	// *****
	logic [23:0] rx_hi; // serial_out taken just before each fall
	initial begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
		rx_hi = '0;
	end
	// Sel low keeps select high: a frame the block must ignore
	task automatic send(input logic [23:0] w, input int n, input logic sel);
		chip_select_n <= ~sel;
		repeat (5) @(posedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in <= w[i];
			repeat (5) @(posedge clk);
			sclk <= 1'b1;
			repeat (5) @(posedge clk);
			sclk <= 1'b0;
			rx_hi <= {rx_hi[22:0], serial_out};
		end
		repeat (5) @(posedge clk);
		chip_select_n <= 1'b1;
		serial_in <= ~serial_in; // Released line shows no stale level
		repeat (8) @(posedge clk);
	endtask
endmodule // qdsc_host
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench of the serial command front end
`timescale 1ns/1ps
`default_nettype none
module testbench
	import qdsc_pkg::*;
;
	logic clk, rst_b, sclk, chip_select_n, serial_in, serial_out;
	logic serial_out_oe, load_strobe_n, clear_n, phase_mode;
	logic psel, penable, pwrite, pready, pslverr, er, so;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, dac_out;
	int n_mismatch = 0;
	int total_checks = 0;

	qdsc_serial_cmd DUT (.clk(clk), .rst_b(rst_b), .sclk(sclk),
		.chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.load_strobe_n(load_strobe_n), .clear_n(clear_n),
		.dac_out(dac_out), .phase_mode(phase_mode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	qdsc_host host (.clk(clk), .serial_out(serial_out), .sclk(sclk),
		.chip_select_n(chip_select_n), .serial_in(serial_in));

	// *****
	// Helpers
	// *****
	task automatic wrap_up;
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// Waits for pready itself; no fixed wait-state count assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20)
			n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string s, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0, rd, er);
		chk(s, e, rd);
	endtask

	// *****
	// Scenarios
	// *****
	task automatic t_reset;
		chk("dac_out", 32'h0, dac_out);
		chk("phase_mode", 32'h1, phase_mode);
		chk("serial_out_oe", 32'h1, serial_out_oe);
		rd_chk("input regs", 12'h008, 32'h0);
		rd_chk("ctrl", 12'h000, 32'h1);
		apb(1'b0, 12'h010, 32'h0, rd, er);
		chk("pslverr", 32'h1, er);
	endtask
	task automatic t_load;
		for (int c = 0; c < 4; c++)
			host.send({2'(c), 2'b01, 8'(8'h11 * (c + 1))}, 12, 1'b1);
		chk("dac_out", 32'h0, dac_out);
		rd_chk("input regs", 12'h008, 32'h44332211);
		host.send(12'hb77, 12, 1'b1);
		chk("dac_out", 32'h00770000, dac_out);
		host.send(12'h200, 12, 1'b1);
		chk("dac_out", 32'h44772211, dac_out);
	endtask
	task automatic t_all;
		host.send(12'h83c, 12, 1'b1);
		chk("dac_out", 32'h3c3c3c3c, dac_out);
		host.send(12'h4ff, 12, 1'b1);
		chk("dac_out", 32'h3c3c3c3c, dac_out);
		rd_chk("input regs", 12'h008, 32'h44772211);
		host.send(16'hd3a5, 16, 1'b1);
		chk("dac_out", 32'h3c3c3ca5, dac_out);
		rd_chk("input regs", 12'h008, 32'h447722a5);
	endtask
	task automatic t_dout;
		host.send({12'h4a5, 12'h4c3}, 24, 1'b1);
		chk("dout rise", 12'h4a5, host.rx_hi[11:0]);
		host.send(12'ha00, 12, 1'b1);
		chk("phase_mode", 32'h0, phase_mode);
		chk("dac_out", 32'h447722a5, dac_out);
		rd_chk("status", 12'h004, 32'h0a000000);
		host.send({12'h4a5, 12'h4c3}, 24, 1'b1);
		chk("dout fall", 11'h252, host.rx_hi[10:0]);
		chk("phase_mode", 32'h0, phase_mode);
		host.send(12'hd66, 12, 1'b1);
		host.send(12'he00, 12, 1'b1);
		chk("phase_mode", 32'h1, phase_mode);
		chk("dac_out", 32'h667722a5, dac_out);
		rd_chk("status", 12'h004, 32'h0e000001);
		rd_chk("dac regs", 12'h00c, 32'h667722a5);
	endtask
	task automatic t_desel;
		so = serial_out;
		host.send(12'h3ee, 12, 1'b0);
		chk("dac_out", 32'h667722a5, dac_out);
		chk("serial_out", so, serial_out);
		apb(1'b1, 12'h000, 32'h0, rd, er);
		host.send(12'h3ee, 12, 1'b1);
		chk("dac_out", 32'h667722a5, dac_out);
		apb(1'b1, 12'h000, 32'h1, rd, er);
	endtask
	task automatic t_pins;
		clear_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("dac_out", 32'h0, dac_out);
		rd_chk("input regs", 12'h008, 32'h0);
		clear_n <= 1'b1;
		repeat (4) @(posedge clk);
		host.send(12'h142, 12, 1'b1);
		chk("dac_out", 32'h0, dac_out);
		load_strobe_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("dac_out", 32'h00000042, dac_out);
		host.send(12'h581, 12, 1'b1);
		chk("dac_out", 32'h00008142, dac_out);
		load_strobe_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// *****
	// Run
	// *****
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		rst_b = 1'b0;
		load_strobe_n = 1'b1;
		clear_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_load();
		t_all();
		t_dout();
		t_desel();
		t_pins();
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

// >>> verilog/qdsc_pkg.sv
// Types shared by the quad converter command interface
`default_nettype none
package qdsc_pkg;

	typedef struct packed {
		logic [1:0] channel_select;
		logic [1:0] command_bits;
		logic [7:0] dac_code;
	} qdsc_word_t;

	typedef enum {
		QDSC_OP_NOP,
		QDSC_OP_LOAD_IN,
		QDSC_OP_LOAD_BOTH,
		QDSC_OP_ALL_DAC,
		QDSC_OP_XFER
	} qdsc_op_t;

endpackage
`default_nettype wire

// >>> verilog/qdsc_regs.svh
// Register offsets, field positions and reset values of the command interface
`ifndef QDSC_REGS_SVH
`define QDSC_REGS_SVH

`define QDSC_CTRL_OFS 12'h000
`define QDSC_STAT_OFS 12'h004
`define QDSC_INREG_OFS 12'h008
`define QDSC_DACREG_OFS 12'h00c

`define QDSC_CTRL_EN_BIT 0
`define QDSC_CTRL_RST 1'b1

`define QDSC_STAT_MODE_BIT 0
`define QDSC_STAT_SEL_BIT 1
`define QDSC_STAT_WORD_LSB 16
`define QDSC_STAT_WORD_MSB 27

`define QDSC_MODE_RST 1'b1
`define QDSC_WORD_RST 12'h000
`define QDSC_CODE_RST 8'h00

`endif

// >>> verilog/qdsc_serial_cmd.sv
// Serial command front end of a quad 8-bit converter, with APB status view
`timescale 1ns/1ps
`default_nettype none
`include "qdsc_regs.svh"

module qdsc_serial_cmd
	import qdsc_pkg::*;
#(
	parameter int CH = 4,
	parameter int DW = 8,
	parameter int WW = 12,
	parameter int AW = 12
) (
	input wire logic clk, // 125 MHz system clock
	input wire logic rst_b, // Synchronous reset, low
	input wire logic sclk, // Serial clock pin
	input wire logic chip_select_n, // Chip select pin, low
	input wire logic serial_in, // Serial data pin
	output logic serial_out, // Serial data out pin
	output logic serial_out_oe, // Output enable of serial_out
	input wire logic load_strobe_n, // Load converter pin, low
	input wire logic clear_n, // Clear pin, low
	output logic [CH*DW-1:0] dac_out, // Converter codes, channel A low
	output logic phase_mode, // 1 rising, 0 falling output phase
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr // APB error
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic sclk_m, sclk_s, sclk_d;
	logic cs_m, cs_s, cs_d;
	logic din_m, din_s;
	logic ld_m, ld_s;
	logic clr_m, clr_s;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			cs_m <= 1'b1;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
			din_m <= 1'b0;
			din_s <= 1'b0;
			ld_m <= 1'b1;
			ld_s <= 1'b1;
			clr_m <= 1'b1;
			clr_s <= 1'b1;
		end else begin
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			cs_m <= chip_select_n;
			cs_s <= cs_m;
			cs_d <= cs_s;
			din_m <= serial_in;
			din_s <= din_m;
			ld_m <= load_strobe_n;
			ld_s <= ld_m;
			clr_m <= clear_n;
			clr_s <= clr_m;
		end
	end

	logic ctrl_en;
	logic sclk_rise, sclk_fall, cs_rise, selected;
	assign selected = !cs_s && ctrl_en;
	assign sclk_rise = sclk_s && !sclk_d && selected;
	assign sclk_fall = !sclk_s && sclk_d && selected;
	assign cs_rise = cs_s && !cs_d && ctrl_en;

	// ************************************************************
	// Shift register and serial output
	// ************************************************************
	logic [WW-1:0] shift_reg;
	logic out_tap;

	// Only the newest twelve bits are kept; a longer word drops its head
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			shift_reg <= `QDSC_WORD_RST;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[WW-2:0], din_s};
		end
	end

	// Tap holds the bit leaving at the last rise, for the falling phase
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			out_tap <= 1'b0;
		end else if (sclk_rise) begin
			out_tap <= shift_reg[WW-1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			serial_out <= 1'b0;
		end else if (phase_mode && sclk_rise) begin
			serial_out <= shift_reg[WW-1];
		end else if (!phase_mode && sclk_fall) begin
			serial_out <= out_tap;
		end
	end

	assign serial_out_oe = 1'b1;

	// ************************************************************
	// Command decode
	// ************************************************************
	qdsc_word_t word;
	qdsc_op_t op;
	logic exec;
	assign word = qdsc_word_t'(shift_reg);
	assign exec = cs_rise && clr_s;

	always_comb begin
		case (word.command_bits)
			2'b01: op = QDSC_OP_LOAD_IN;
			2'b11: op = QDSC_OP_LOAD_BOTH;
			2'b00: op = word.channel_select[0] ? QDSC_OP_NOP
				: QDSC_OP_ALL_DAC;
			2'b10: op = QDSC_OP_XFER;
			default: op = QDSC_OP_NOP;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase_mode <= `QDSC_MODE_RST;
		end else if (exec && op == QDSC_OP_XFER && word.channel_select[1]) begin
			phase_mode <= word.channel_select[0];
		end
	end

	logic [WW-1:0] last_word;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_word <= `QDSC_WORD_RST;
		end else if (exec) begin
			last_word <= shift_reg;
		end
	end

	// ************************************************************
	// Input and converter registers
	// ************************************************************
	// Pins are sampled, so clear and load act within three clocks
	logic [DW-1:0] in_reg [CH];
	logic [DW-1:0] dac_reg [CH];
	logic [DW-1:0] next_in [CH];
	logic [CH*DW-1:0] in_flat;

	genvar gi;
	generate
		for (gi = 0; gi < CH; gi++) begin : g_ch
			logic hit;
			assign hit = word.channel_select == 2'(gi);

			always_comb begin
				next_in[gi] = in_reg[gi];
				if (exec && hit && (op == QDSC_OP_LOAD_IN
					|| op == QDSC_OP_LOAD_BOTH)) begin
					next_in[gi] = word.dac_code;
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_b || !clr_s) begin
					in_reg[gi] <= `QDSC_CODE_RST;
				end else begin
					in_reg[gi] <= next_in[gi];
				end
			end

			// Broadcast load wins over transparency for its own cycle
			always_ff @(posedge clk) begin
				if (!rst_b || !clr_s) begin
					dac_reg[gi] <= `QDSC_CODE_RST;
				end else if (exec && op == QDSC_OP_ALL_DAC) begin
					dac_reg[gi] <= word.dac_code;
				end else if (!ld_s) begin
					dac_reg[gi] <= next_in[gi];
				end else if (exec && hit && op == QDSC_OP_LOAD_BOTH) begin
					dac_reg[gi] <= word.dac_code;
				end else if (exec && op == QDSC_OP_XFER) begin
					dac_reg[gi] <= in_reg[gi];
				end
			end

			assign dac_out[gi*DW +: DW] = dac_reg[gi];
			assign in_flat[gi*DW +: DW] = in_reg[gi];
		end
	endgenerate

	// ************************************************************
	// APB slave
	// ************************************************************
	logic setup_rd, access_wr, mapped;
	assign setup_rd = psel && !penable;
	assign access_wr = psel && penable && pwrite;
	assign pready = psel && penable;
	assign mapped = paddr == `QDSC_CTRL_OFS || paddr == `QDSC_STAT_OFS
		|| paddr == `QDSC_INREG_OFS || paddr == `QDSC_DACREG_OFS;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_en <= `QDSC_CTRL_RST;
		end else if (access_wr && paddr == `QDSC_CTRL_OFS) begin
			ctrl_en <= pwdata[`QDSC_CTRL_EN_BIT];
		end
	end

	// Read data is taken in setup so the access phase needs no wait
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_rd) begin
			pslverr <= !mapped;
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					`QDSC_CTRL_OFS: prdata[`QDSC_CTRL_EN_BIT] <= ctrl_en;
					`QDSC_STAT_OFS: begin
						prdata[`QDSC_STAT_MODE_BIT] <= phase_mode;
						prdata[`QDSC_STAT_SEL_BIT] <= !cs_s;
						prdata[`QDSC_STAT_WORD_MSB:`QDSC_STAT_WORD_LSB]
							<= last_word;
					end
					`QDSC_INREG_OFS: prdata <= 32'(in_flat);
					`QDSC_DACREG_OFS: prdata <= 32'(dac_out);
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_shift_in;
		sclk_rise ##0 !cs_s;
	endsequence

	sequence s_exec_word(logic [3:0] hdr);
		exec ##0 {word.channel_select, word.command_bits} == hdr;
	endsequence

	property p_por;
		@(posedge clk) disable iff (1'b0)
		!rst_b |=> phase_mode && in_flat == '0 && dac_out == '0;
	endproperty
	a_por: assert property (p_por) else $error("reset state wrong");

	property p_shift;
		s_shift_in |=> shift_reg == {$past(shift_reg[WW-2:0]), $past(din_s)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift wrong");

	property p_hold;
		cs_s |=> $stable(serial_out) && $stable(shift_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("moved while idle");

	property p_drive;
		serial_out_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("output released");

	property p_exec_only;
		ld_s && clr_s && !exec |=> $stable(dac_out) && $stable(in_flat);
	endproperty
	a_exec_only: assert property (p_exec_only) else $error("stray update");

	property p_nop;
		(exec && op == QDSC_OP_NOP && ld_s) |=> $stable(dac_out)
			&& $stable(in_flat);
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state");

	property p_mode1;
		s_exec_word(4'b1110) |=> phase_mode ##2 phase_mode;
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 1 not set");

	property p_mode0;
		s_exec_word(4'b1010) |=> !phase_mode;
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 not set");

	property p_mode_keep;
		!(exec && op == QDSC_OP_XFER) |=> $stable(phase_mode);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode drift");

	property p_clear;
		!clr_s |=> in_flat == '0 && dac_out == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear missed");

	property p_transp;
		!ld_s && clr_s && !exec |=> dac_out == in_flat;
	endproperty
	a_transp: assert property (p_transp) else $error("not transparent");

	property p_load_in;
		exec && op == QDSC_OP_LOAD_IN && ld_s |=> $stable(dac_out);
	endproperty
	a_load_in: assert property (p_load_in) else $error("dac touched");

endmodule // qdsc_serial_cmd
`default_nettype wire
